// >>> logic/vsm_pkg.sv
`default_nettype none
package vsm_pkg;
    // ========================================
    // timing
    localparam int  VSM_CLK_HZ        = 100_000_000;
    localparam real VSM_CLK_NS        = 10.0;
    localparam int  VSM_BAUD_BPS      = 460_800;
    localparam int  VSM_CLKS_PER_BIT  = VSM_CLK_HZ / VSM_BAUD_BPS;
    localparam real VSM_VEL_STEP_US   = 167.0;
    localparam real VSM_DISP_STEP_MS  = 1.67;
    localparam real VSM_INIT_TIME_MS  = 970.0;
    localparam int  VSM_VEL_STEP_CYC  = int'(VSM_VEL_STEP_US * 1.0E3 / VSM_CLK_NS);
    localparam int  VSM_DISP_STEP_CYC = int'(VSM_DISP_STEP_MS * 1.0E6 / VSM_CLK_NS);
    localparam int  VSM_INIT_CYC      = int'($floor(VSM_INIT_TIME_MS * 1.0E6 / VSM_CLK_NS));
    localparam int  VSM_OUT_DIV       = 2;
    // ========================================
    // register map
    localparam logic [6:0] VSM_ADDR_SIG   = 7'h00;
    localparam logic [6:0] VSM_ADDR_MODE  = 7'h02;
    localparam logic [6:0] VSM_ADDR_UART  = 7'h08;
    localparam logic [6:0] VSM_ADDR_COUNT = 7'h0A;
    localparam logic [6:0] VSM_ADDR_GLOB  = 7'h0A;
    localparam logic [6:0] VSM_ADDR_BURST = 7'h0C;
    localparam logic [6:0] VSM_ADDR_THERMAL_STATUS_TWO = 7'h2E;
    localparam logic [6:0] VSM_ADDR_BANK  = 7'h7E;
    localparam logic [7:0] VSM_BANK_W1    = 8'h01;
    localparam logic [15:0] VSM_REG_RESET = 16'h0000;
    // ========================================
    // fields
    localparam int VSM_MODE_CMD_LSB = 8;
    localparam int VSM_MODE_STAT    = 10;
    localparam int VSM_SOFT_RST     = 7;
    localparam int VSM_UART_AUTO    = 0;
    localparam int VSM_AUTO_START   = 1;
    localparam int VSM_COUNT_OUT    = 1;
    localparam int VSM_TEMP_OUT     = 14;
    localparam int VSM_TEMP_SEL     = 1;
    localparam logic [1:0] VSM_CMD_TO_SAMP = 2'h2;
    localparam logic [1:0] VSM_CMD_TO_CFG  = 2'h1;
    localparam logic [7:0] VSM_BYTE_CR     = 8'h0D;
    localparam logic [7:0] VSM_BYTE_HDR    = 8'h80;
    // ========================================
    // types
    typedef enum logic [1:0] {VSM_INIT, VSM_CONFIG, VSM_SAMPLE} vsm_mode_e;
    typedef struct packed {
        logic       write;
        logic [6:0] addr;
        logic [7:0] data;
    } vsm_req_s;
endpackage
`default_nettype wire

// >>> logic/vsm_tick_counter.sv
`default_nettype none
module vsm_tick_counter import vsm_pkg::*; #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             clear,
    input  wire logic [31:0]      period,
    output logic                  tick,
    output logic [WIDTH-1:0]      count
);
    logic [31:0]      cyc_reg;
    logic [31:0]      cyc_next;
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    always_comb begin
        tick       = !clear && (cyc_reg >= period - 32'h1);
        cyc_next   = cyc_reg + 32'h1;
        count_next = count_reg;
        if (clear) begin
            cyc_next   = '0;
            count_next = '0;
        end else if (tick) begin
            cyc_next   = '0;
            count_next = count_reg + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cyc_reg   <= '0;
            count_reg <= '0;
        end else begin
            cyc_reg   <= cyc_next;
            count_reg <= count_next;
        end
    end

    assign count = count_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_tally_step: assert property (tick |=> count == $past(count) + 1'b1)
        else $error("tally did not step on tick");
    a_tally_wrap: assert property (tick && &count |=> count == '0)
        else $error("tally did not wrap");
    a_tally_hold: assert property (!tick && !clear |=> $stable(count))
        else $error("tally moved without tick");
endmodule
`default_nettype wire

// >>> logic/vsm_uart.sv
`default_nettype none
module vsm_uart import vsm_pkg::*; #(
    parameter int CLKS_PER_BIT = VSM_CLKS_PER_BIT
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       rxLine,
    input  wire logic [7:0] txData,
    input  wire logic       txValid,
    output logic            txReady,
    output logic [7:0]      rxData,
    output logic            rxValid,
    output logic            txLine
);
    localparam logic [15:0] FULL = 16'(CLKS_PER_BIT - 1);
    localparam logic [15:0] HALF = 16'(CLKS_PER_BIT / 2);
    logic        rxBusy_reg, rxBusy_next, rxValid_reg, rxValid_next;
    logic [15:0] rxCnt_reg, rxCnt_next, txCnt_reg, txCnt_next;
    logic [3:0]  rxBit_reg, rxBit_next, txBit_reg, txBit_next;
    logic [7:0]  rxSh_reg, rxSh_next;
    logic        txBusy_reg, txBusy_next;
    logic [9:0]  txSh_reg, txSh_next;

    // ========================================
    // receive and transmit
    always_comb begin
        rxBusy_next  = rxBusy_reg;
        rxCnt_next   = rxCnt_reg - 16'h1;
        rxBit_next   = rxBit_reg;
        rxSh_next    = rxSh_reg;
        rxValid_next = 1'b0;
        if (!rxBusy_reg) begin
            rxCnt_next = HALF;
            rxBit_next = '0;
            rxBusy_next = !rxLine;
        end else if (rxCnt_reg == '0) begin
            rxCnt_next = FULL;
            rxBit_next = rxBit_reg + 4'h1;
            if (rxBit_reg == 4'h0 && rxLine) begin
                rxBusy_next = 1'b0;
            end else if (rxBit_reg == 4'h9) begin
                rxBusy_next  = 1'b0;
                rxValid_next = rxLine;
            end else if (rxBit_reg != 4'h0) begin
                rxSh_next = {rxLine, rxSh_reg[7:1]};
            end
        end
        txReady     = !txBusy_reg;
        txBusy_next = txBusy_reg;
        txCnt_next  = txCnt_reg - 16'h1;
        txBit_next  = txBit_reg;
        txSh_next   = txSh_reg;
        if (!txBusy_reg) begin
            if (txValid) begin
                txBusy_next = 1'b1;
                txSh_next   = {1'b1, txData, 1'b0};
                txCnt_next  = FULL;
                txBit_next  = '0;
            end
        end else if (txCnt_reg == '0) begin
            txCnt_next = FULL;
            txSh_next  = {1'b1, txSh_reg[9:1]};
            txBit_next = txBit_reg + 4'h1;
            txBusy_next = txBit_reg != 4'h9;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rxBusy_reg <= 1'b0; rxCnt_reg <= '0; rxBit_reg <= '0;
            rxSh_reg <= '0; rxValid_reg <= 1'b0;
            txBusy_reg <= 1'b0; txCnt_reg <= '0; txBit_reg <= '0;
            txSh_reg <= '1;
        end else begin
            rxBusy_reg <= rxBusy_next; rxCnt_reg <= rxCnt_next; rxBit_reg <= rxBit_next;
            rxSh_reg <= rxSh_next; rxValid_reg <= rxValid_next;
            txBusy_reg <= txBusy_next; txCnt_reg <= txCnt_next; txBit_reg <= txBit_next;
            txSh_reg <= txSh_next;
        end
    end

    assign rxData  = rxSh_reg;
    assign rxValid = rxValid_reg;
    assign txLine  = txBusy_reg ? txSh_reg[0] : 1'b1;
endmodule
`default_nettype wire

// >>> logic/vsm_mode_counter.sv
`default_nettype none
module vsm_mode_counter import vsm_pkg::*; #(
    parameter int INIT_CYC      = VSM_INIT_CYC,
    parameter int VEL_STEP_CYC  = VSM_VEL_STEP_CYC,
    parameter int DISP_STEP_CYC = VSM_DISP_STEP_CYC,
    parameter int CLKS_PER_BIT  = VSM_CLKS_PER_BIT,
    parameter int OUT_DIV       = VSM_OUT_DIV
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic receivePairLevel,
    input  wire logic displacementSel,
    output logic      transmitPairPositive,
    output logic      transmitPairNegative,
    output logic      samplingActive,
    output logic      initBusy
);
    vsm_mode_e        mode_reg, mode_next;
    logic [31:0]      initCnt_reg, initCnt_next;
    logic [15:0]      sigCtrl_reg, sigCtrl_next;
    logic [15:0]      uartCtrl_reg, uartCtrl_next;
    logic [15:0]      burstCtrl_reg, burstCtrl_next;
    logic [7:0]       bank_reg, bank_next;
    logic [1:0]       rxIdx_reg, rxIdx_next;
    logic [7:0]       byte0_reg, byte0_next, byte1_reg, byte1_next;
    logic             pktBusy_reg, pktBusy_next;
    logic [2:0]       pktIdx_reg, pktIdx_next;
    logic [5:0]       pktMask_reg, pktMask_next;
    logic [5:0][7:0]  pktBuf_reg, pktBuf_next;
    vsm_req_s         req;
    logic             reqValid, inW1, isBurst, wrEn, rdEn, cfgWr;
    logic             softRst, modeWr, startSmp, autoStart;
    logic [1:0]       modeCmd;
    logic [15:0]      rdWord, sampleCount;
    logic [1:0]       shortRateTally;
    logic             sampleTick, outTick, clearCnt;
    logic [31:0]      stepPeriod;
    logic [7:0]       uRxData, txByte;
    logic             uRxValid, txValid, txReady, txLine;

    // ========================================
    // serial link
    vsm_uart #(
        .CLKS_PER_BIT (CLKS_PER_BIT)
    ) u_uart (
        .clk     (clk),
        .rst     (rst),
        .rxLine  (receivePairLevel),
        .txData  (txByte),
        .txValid (txValid),
        .txReady (txReady),
        .rxData  (uRxData),
        .rxValid (uRxValid),
        .txLine  (txLine)
    );

    // ========================================
    // sample counters
    assign clearCnt   = mode_reg == VSM_INIT;
    assign stepPeriod = displacementSel ? 32'(DISP_STEP_CYC) : 32'(VEL_STEP_CYC);

    vsm_tick_counter #(
        .WIDTH (16)
    ) u_sample_tally (
        .clk    (clk),
        .rst    (rst),
        .clear  (clearCnt),
        .period (stepPeriod),
        .tick   (sampleTick),
        .count  (sampleCount)
    );

    vsm_tick_counter #(
        .WIDTH (2)
    ) u_short_tally (
        .clk    (clk),
        .rst    (rst),
        .clear  (clearCnt),
        .period (32'(stepPeriod * 32'(OUT_DIV))),
        .tick   (outTick),
        .count  (shortRateTally)
    );

    // ========================================
    // command decode
    always_comb begin
        rxIdx_next = rxIdx_reg;
        byte0_next = byte0_reg;
        byte1_next = byte1_reg;
        reqValid   = 1'b0;
        req        = '{write: byte0_reg[7], addr: byte0_reg[6:0], data: byte1_reg};
        if (mode_reg == VSM_INIT) begin
            rxIdx_next = '0;
        end else if (uRxValid) begin
            case (rxIdx_reg)
                2'h0: begin
                    byte0_next = uRxData;
                    rxIdx_next = 2'h1;
                end
                2'h1: begin
                    byte1_next = uRxData;
                    rxIdx_next = 2'h2;
                end
                default: begin
                    rxIdx_next = '0;
                    reqValid   = uRxData == VSM_BYTE_CR;
                end
            endcase
        end
    end

    assign inW1    = bank_reg == VSM_BANK_W1;
    assign isBurst = reqValid && byte0_reg == VSM_BYTE_HDR && byte1_reg == 8'h00 && mode_reg == VSM_SAMPLE;
    assign wrEn    = reqValid && req.write && !isBurst;
    assign rdEn    = reqValid && !req.write;
    assign cfgWr   = wrEn && mode_reg == VSM_CONFIG;
    assign softRst = wrEn && inW1 && req.addr == VSM_ADDR_GLOB && req.data[VSM_SOFT_RST];
    assign modeWr  = wrEn && !inW1 && req.addr == (VSM_ADDR_MODE | 7'h01);
    assign modeCmd = req.data[VSM_MODE_CMD_LSB-8 +: 2];
    assign autoStart = uartCtrl_reg[VSM_UART_AUTO] && uartCtrl_reg[VSM_AUTO_START];

    // ========================================
    // operating mode
    always_comb begin
        mode_next    = mode_reg;
        initCnt_next = initCnt_reg;
        case (mode_reg)
            VSM_INIT: begin
                if (initCnt_reg == '0) begin
                    mode_next = autoStart ? VSM_SAMPLE : VSM_CONFIG;
                end else begin
                    initCnt_next = initCnt_reg - 32'h1;
                end
            end
            VSM_CONFIG: begin
                if (modeWr && modeCmd == VSM_CMD_TO_SAMP) begin
                    mode_next = VSM_SAMPLE;
                end
            end
            VSM_SAMPLE: begin
                if (modeWr && modeCmd == VSM_CMD_TO_CFG) begin
                    mode_next = VSM_CONFIG;
                end
            end
            default: mode_next = VSM_INIT;
        endcase
        if (softRst) begin
            mode_next    = VSM_INIT;
            initCnt_next = 32'(INIT_CYC - 1);
        end
    end

    // ========================================
    // configuration registers
    always_comb begin
        sigCtrl_next   = sigCtrl_reg;
        uartCtrl_next  = uartCtrl_reg;
        burstCtrl_next = burstCtrl_reg;
        bank_next      = bank_reg;
        if (cfgWr && inW1) begin
            case (req.addr)
                VSM_ADDR_SIG:           sigCtrl_next[7:0]    = req.data;
                VSM_ADDR_SIG | 7'h01:   sigCtrl_next[15:8]   = req.data;
                VSM_ADDR_UART:          uartCtrl_next[7:0]   = req.data;
                VSM_ADDR_UART | 7'h01:  uartCtrl_next[15:8]  = req.data;
                VSM_ADDR_BURST:         burstCtrl_next[7:0]  = req.data;
                VSM_ADDR_BURST | 7'h01: burstCtrl_next[15:8] = req.data;
                default: ;
            endcase
        end
        if (wrEn && req.addr == VSM_ADDR_BANK) begin
            bank_next = req.data;
        end
        if (softRst) begin
            bank_next = '0;
        end
    end

    // ========================================
    // read data, window resolved
    always_comb begin
        rdWord = '0;
        if ({req.addr[6:1], 1'b0} == VSM_ADDR_BANK) begin
            rdWord = {8'h00, bank_reg};
        end else if (!inW1) begin
            case ({req.addr[6:1], 1'b0})
                VSM_ADDR_MODE:  rdWord[VSM_MODE_STAT] = mode_reg == VSM_CONFIG;
                VSM_ADDR_COUNT: rdWord = sampleCount;
                VSM_ADDR_THERMAL_STATUS_TWO: rdWord = {14'h0, shortRateTally};
                default: ;
            endcase
        end else begin
            case ({req.addr[6:1], 1'b0})
                VSM_ADDR_SIG:   rdWord = sigCtrl_reg;
                VSM_ADDR_UART:  rdWord = uartCtrl_reg;
                VSM_ADDR_BURST: rdWord = burstCtrl_reg;
                default: ;
            endcase
        end
    end

    // ========================================
    // response and sample packets
    assign startSmp = isBurst || (mode_reg == VSM_SAMPLE && uartCtrl_reg[VSM_UART_AUTO] && outTick);
    assign txValid  = pktBusy_reg && pktMask_reg[pktIdx_reg] && mode_reg != VSM_INIT;
    assign txByte   = pktBuf_reg[pktIdx_reg];

    always_comb begin
        pktBusy_next = pktBusy_reg;
        pktIdx_next  = pktIdx_reg;
        pktMask_next = pktMask_reg;
        pktBuf_next  = pktBuf_reg;
        if (!pktBusy_reg) begin
            pktIdx_next = '0;
            if (rdEn) begin
                pktBusy_next   = 1'b1;
                pktMask_next   = 6'h0F;
                pktBuf_next[0] = byte0_reg;
                pktBuf_next[1] = rdWord[15:8];
                pktBuf_next[2] = rdWord[7:0];
                pktBuf_next[3] = VSM_BYTE_CR;
            end else if (startSmp) begin
                pktBusy_next   = 1'b1;
                pktMask_next   = {1'b1, {2{burstCtrl_reg[VSM_TEMP_OUT] && sigCtrl_reg[VSM_TEMP_SEL]}},
                                  {2{burstCtrl_reg[VSM_COUNT_OUT]}}, 1'b1};
                pktBuf_next[0] = VSM_BYTE_HDR;
                pktBuf_next[1] = sampleCount[15:8];
                pktBuf_next[2] = sampleCount[7:0];
                pktBuf_next[3] = 8'h00;
                pktBuf_next[4] = {6'h00, shortRateTally};
                pktBuf_next[5] = VSM_BYTE_CR;
            end
        end else if ((txValid && txReady) || !pktMask_reg[pktIdx_reg]) begin
            pktIdx_next  = pktIdx_reg + 3'h1;
            pktBusy_next = pktIdx_reg != 3'h5;
        end
        if (softRst || mode_reg == VSM_INIT) begin
            pktBusy_next = 1'b0;
        end
    end

    // ========================================
    // state registers
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg      <= VSM_INIT;
            initCnt_reg   <= 32'(INIT_CYC - 1);
            sigCtrl_reg   <= VSM_REG_RESET;
            uartCtrl_reg  <= VSM_REG_RESET;
            burstCtrl_reg <= VSM_REG_RESET;
            bank_reg      <= '0;
            rxIdx_reg     <= '0;
            byte0_reg     <= '0;
            byte1_reg     <= '0;
            pktBusy_reg   <= 1'b0;
            pktIdx_reg    <= '0;
            pktMask_reg   <= '0;
            pktBuf_reg    <= '0;
        end else begin
            mode_reg      <= mode_next;
            initCnt_reg   <= initCnt_next;
            sigCtrl_reg   <= sigCtrl_next;
            uartCtrl_reg  <= uartCtrl_next;
            burstCtrl_reg <= burstCtrl_next;
            bank_reg      <= bank_next;
            rxIdx_reg     <= rxIdx_next;
            byte0_reg     <= byte0_next;
            byte1_reg     <= byte1_next;
            pktBusy_reg   <= pktBusy_next;
            pktIdx_reg    <= pktIdx_next;
            pktMask_reg   <= pktMask_next;
            pktBuf_reg    <= pktBuf_next;
        end
    end

    assign transmitPairPositive = txLine;
    assign transmitPairNegative = !txLine;
    assign samplingActive       = mode_reg == VSM_SAMPLE;
    assign initBusy             = mode_reg == VSM_INIT;

    // ========================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_init_to_cfg: assert property (mode_reg == VSM_INIT && initCnt_reg == '0 && !autoStart && !softRst
        |=> mode_reg == VSM_CONFIG) else $error("init did not end in config");
    a_init_to_samp: assert property (mode_reg == VSM_INIT && initCnt_reg == '0 && autoStart && !softRst
        |=> mode_reg == VSM_SAMPLE) else $error("auto start did not sample");
    a_soft_reset: assert property (softRst |=> mode_reg == VSM_INIT && initCnt_reg == 32'(INIT_CYC - 1))
        else $error("soft reset ignored");
    a_mode_return: assert property (mode_reg == VSM_SAMPLE && modeWr && modeCmd == VSM_CMD_TO_CFG && !softRst
        |=> mode_reg == VSM_CONFIG) else $error("mode command 01 ignored");
    a_mode_enter: assert property (mode_reg == VSM_CONFIG && modeWr && modeCmd == VSM_CMD_TO_SAMP && !softRst
        |=> mode_reg == VSM_SAMPLE) else $error("mode command 10 ignored");
    a_samp_block: assert property (mode_reg == VSM_SAMPLE
        |=> $stable(sigCtrl_reg) && $stable(uartCtrl_reg) && $stable(burstCtrl_reg))
        else $error("write acted while sampling");
    a_bank_write: assert property (wrEn && req.addr == VSM_ADDR_BANK && !softRst |=> bank_reg == $past(req.data))
        else $error("bank select not written");
    a_init_quiet: assert property (mode_reg == VSM_INIT |-> !txValid && !pktBusy_next)
        else $error("transmit during init");
    a_count_field: assert property (!pktBusy_reg && !rdEn && startSmp && mode_reg != VSM_INIT && !softRst
        |=> pktMask_reg[1] == burstCtrl_reg[VSM_COUNT_OUT] && pktBuf_reg[2] == $past(sampleCount[7:0]))
        else $error("tally field wrong in packet");
    a_auto_packet: assert property (mode_reg == VSM_SAMPLE && uartCtrl_reg[VSM_UART_AUTO] && outTick
        && !pktBusy_reg && !softRst |=> pktBusy_reg && txValid) else $error("auto packet missing");
    a_window_sel: assert property (rdEn && !inW1 && req.addr == VSM_ADDR_COUNT && !pktBusy_reg
        |=> {pktBuf_reg[1], pktBuf_reg[2]} == $past(sampleCount)) else $error("window 0 read wrong");

    c_auto_start: cover property (mode_reg == VSM_INIT ##1 mode_reg == VSM_SAMPLE);
    c_soft_reset: cover property (mode_reg == VSM_SAMPLE && softRst);
    c_read_resp:  cover property (rdEn ##1 pktBusy_reg);
    c_burst_pkt:  cover property (isBurst ##1 pktBusy_reg);
endmodule
`default_nettype wire

// >>> verif/vsm_host_model.sv
`default_nettype none
module vsm_host_model import vsm_pkg::*; #(
    parameter int BIT_CYC = 8
) (
    input  wire logic clk,
    input  wire logic txPos,
    output var logic  rxLine
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================
    // host side of the link
    initial rxLine = 1'b1;
    task automatic sendByte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxLine = f[i];
            repeat (BIT_CYC) @(negedge clk);
        end
    endtask
    task automatic request(input logic wr, input logic [6:0] a, input logic [7:0] d);
        sendByte({wr, a});
        sendByte(d);
        sendByte(VSM_BYTE_CR);
    endtask
    task automatic getByte(output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        while (txPos !== 1'b0 && n < 9000) begin
            @(negedge clk);
            n++;
        end
        ok = (n < 9000);
        repeat (BIT_CYC / 2) @(negedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(negedge clk);
            b[i] = txPos;
        end
        repeat (BIT_CYC) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// >>> verif/vsm_mode_counter_test.sv
`default_nettype none
module vsm_mode_counter_test import vsm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] bank; logic [6:0] addr; logic [7:0] data; logic [15:0] exp;} vsm_row_s;
    logic        clk, rst, rxLine, dispSel, txPos, txNeg, sampling, busy, ok;
    logic [7:0]  b0, b1, b2, b3;
    logic [15:0] v, c1;
    int          fails = 0;
    int          compares = 0;
    vsm_row_s    rows [6] = '{'{8'h01, 7'h00, 8'h02, 16'h0002}, '{8'h01, 7'h0C, 8'h02, 16'h0002},
        '{8'h01, 7'h0A, 8'h00, 16'h0000}, '{8'h01, 7'h02, 8'h55, 16'h0000},
        '{8'h00, 7'h00, 8'h33, 16'h0000}, '{8'h00, 7'h40, 8'h5A, 16'h0000}};
    vsm_mode_counter #(.INIT_CYC(50), .VEL_STEP_CYC(20), .DISP_STEP_CYC(40), .CLKS_PER_BIT(8), .OUT_DIV(2)) dut_u (
        .clk(clk), .rst(rst), .receivePairLevel(rxLine), .displacementSel(dispSel),
        .transmitPairPositive(txPos), .transmitPairNegative(txNeg), .samplingActive(sampling), .initBusy(busy));
    vsm_host_model host_u (.clk(clk), .txPos(txPos), .rxLine(rxLine));
    // ========================================
    // shared tasks
    task automatic results();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic readReg(input logic [6:0] a, output logic [15:0] r);
        host_u.request(1'b0, a, 8'h00);
        host_u.getByte(b0, ok);
        host_u.getByte(b1, ok);
        host_u.getByte(b2, ok);
        host_u.getByte(b3, ok);
        if (ok !== 1'b1) begin
            fails++;
            results();
        end
        check("frame", {1'b0, a, VSM_BYTE_CR}, {b0, b3});
        r = {b1, b2};
    endtask
    task automatic waitIdle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n >= 200) begin
            fails++;
            results();
        end
        repeat (2) @(negedge clk);
    endtask
    // ========================================
    // stimulus
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        dispSel = 1'b0;
        repeat (5) @(negedge clk);
        check("init busy", 16'h0001, {15'h0, busy});
        rst = 1'b0;
        waitIdle();
        foreach (rows[i]) begin
            host_u.request(1'b1, VSM_ADDR_BANK, rows[i].bank);
            host_u.request(1'b1, rows[i].addr, rows[i].data);
            readReg(rows[i].addr, v);
            check("register", rows[i].exp, v);
            $display("row %0d done", i);
        end
        readReg(VSM_ADDR_MODE, v);
        check("mode status", 16'h0400, v);
        readReg(VSM_ADDR_COUNT, c1);
        readReg(VSM_ADDR_COUNT, v);
        check("tally moves", 16'h0001, {15'h0, v > c1});
        host_u.request(1'b1, 7'h03, {6'h00, VSM_CMD_TO_SAMP});
        check("sampling", 16'h0001, {15'h0, sampling});
        host_u.request(1'b1, VSM_ADDR_BANK, VSM_BANK_W1);
        host_u.request(1'b1, VSM_ADDR_BURST, 8'h00);
        host_u.request(1'b1, VSM_ADDR_BANK, 8'h00);
        host_u.request(1'b1, 7'h03, {6'h00, VSM_CMD_TO_CFG});
        check("config", 16'h0000, {15'h0, sampling});
        host_u.request(1'b1, VSM_ADDR_BANK, VSM_BANK_W1);
        readReg(VSM_ADDR_BURST, v);
        check("ignored write", 16'h0002, v);
        $display("mode test done");
        host_u.request(1'b1, VSM_ADDR_UART, 8'h03);
        host_u.request(1'b1, VSM_ADDR_GLOB, 8'h80);
        check("soft reset", 16'h0001, {15'h0, busy});
        waitIdle();
        check("auto start", 16'h0001, {15'h0, sampling});
        host_u.getByte(b0, ok);
        host_u.getByte(b1, ok);
        host_u.getByte(b2, ok);
        host_u.getByte(b3, ok);
        check("auto packet", {VSM_BYTE_HDR, VSM_BYTE_CR}, {b0, b3});
        check("tx pair", {15'h0, ~txPos}, {15'h0, txNeg});
        host_u.request(1'b1, 7'h03, {6'h00, VSM_CMD_TO_CFG});
        check("leave auto", 16'h0000, {15'h0, sampling});
        $display("auto test done");
        results();
    end
endmodule
`default_nettype wire
